// File: sbrd_consts.svh
// constants for the shared bus region decoder
`ifndef SBRD_CONSTS_SVH
`define SBRD_CONSTS_SVH
`define SBRD_LOCAL_BASE    32'h70000000
`define SBRD_LOCAL_LAST    32'h70ffffff
`define SBRD_SWITCH_BASE   32'h71000000
`define SBRD_SWITCH_LAST   32'h71ffffff
`define SBRD_REGS_BASE     32'h70000000
`define SBRD_REGS_LAST     32'h7fffffff
`define SBRD_FLASH_BASE    32'h40000000
`define SBRD_FLASH_LAST    32'h4fffffff
`define SBRD_FLASH_LOW     32'h00000000
`define SBRD_FLASH_LOWLAST 32'h0fffffff
`define SBRD_DDR_BASE      32'h80000000
`define SBRD_DDR_LAST      32'hbfffffff
`define SBRD_PCIE_BASE     32'hc0000000
`define SBRD_RESET_VECTOR  32'h00000000
`define SBRD_FULL_WORD     4'hf
`define SBRD_CLK_NS        100
`define SBRD_LOCAL_CYC     2
`define SBRD_SLOW_NS       1000
`define SBRD_FAST_NS       100
`endif

// File: sbrd_pkg.sv
// types for the shared bus region decoder
package sbrd_pkg;
  typedef enum logic [2:0] {
    RegionNone,
    RegionLocal,
    RegionSwitch,
    RegionFlash,
    RegionDdr,
    RegionPcie
  } sbrd_region_type;

  typedef enum logic [1:0] {
    BufIdle,
    BufBusy,
    BufRead
  } sbrd_state_type;
endpackage

// File: sbrd_decoder.sv
// shared bus region decoder and register access bridge
`timescale 1ns/1ps
`include "sbrd_consts.svh"

// Summary of operation
// - registers are 32 bits; only full-word accesses
// - register writes are posted through a one-word buffer
// - new register write while buffer busy stalls the bus
// - register read stalls the bus until data returns
// - read after write waits until the buffered write completes
// - 0x70000000..0x70FFFFFF decode to fast local registers
// - 0x71000000..0x71FFFFFF go to the slow switch register bus
// - two fast switch targets complete in about a tenth microsecond
// - several processors at once may lengthen register latency
// - flash region read starts a flash read on the serial pins
// - flash region is read-only; writes go via serial master
// - DDR3 region accesses go to the memory controller
// - PCIe region accesses become outbound PCIe requests
// - automatic boot fetches from serial flash byte zero
// - reset vector segment maps to bus address zero
// - two interrupt lines drive processor inputs 0 and 1
// - big-endian mode swaps byte lanes at the processor boundary
// - endianness from strap, or config input when booting manually
// - debug strap low attaches test port to debug controller
// - with auto boot off, registers may release the processor
// - inbound PCIe behaves like processor access on the bus
// - slave ports reach the shared bus via the access block
module sbrd_decoder #(
  parameter int AW          = 32,
  parameter int DW          = 32,
  parameter int SLOW_CYCLES = (`SBRD_SLOW_NS + `SBRD_CLK_NS - 1) / `SBRD_CLK_NS,
  parameter int FAST_CYCLES = (`SBRD_FAST_NS + `SBRD_CLK_NS - 1) / `SBRD_CLK_NS
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          busReq,
  input  wire logic          busWrite,
  input  wire logic [AW-1:0] busAddr,
  input  wire logic [DW-1:0] busWdata,
  input  wire logic [3:0]    busBe,
  input  wire logic          busFromCpu,
  output logic               busStall,
  output logic               busRvalid,
  output logic [DW-1:0]      busRdata,
  output logic               busUnsupported,
  input  wire logic          bootMode,
  input  wire logic          autoBootStrap,
  input  wire logic          bigEndianStrap,
  input  wire logic          bigEndianCfg,
  input  wire logic          cpuStartCfg,
  output logic               cpuRun,
  output logic               cpuBigEndian,
  output logic [AW-1:0]      cpuResetVector,
  input  wire logic          debug_attach_strap_n,
  output logic               debugAttach,
  input  wire logic [1:0]    devIrq,
  output logic [1:0]         cpuIrqIn,
  output logic               localReq,
  output logic               localWrite,
  output logic [AW-1:0]      localAddr,
  output logic [DW-1:0]      localWdata,
  input  wire logic [DW-1:0] localRdata,
  input  wire logic          fastTarget,
  output logic               switchReq,
  output logic               switchWrite,
  output logic [AW-1:0]      switchAddr,
  output logic [DW-1:0]      switchWdata,
  input  wire logic          switchDone,
  input  wire logic [DW-1:0] switchRdata,
  output logic               flashReadReq,
  output logic [AW-1:0]      flashAddr,
  input  wire logic          flashDone,
  input  wire logic [DW-1:0] flashRdata,
  output logic               ddrReq,
  output logic               ddrWrite,
  output logic [AW-1:0]      ddrAddr,
  output logic [DW-1:0]      ddrWdata,
  output logic [3:0]         ddrBe,
  input  wire logic          ddrDone,
  input  wire logic [DW-1:0] ddrRdata,
  output logic               pcieReq,
  output logic               pcieWrite,
  output logic [AW-1:0]      pcieAddr,
  output logic [DW-1:0]      pcieWdata,
  output logic [3:0]         pcieBe,
  input  wire logic          pcieDone,
  input  wire logic [DW-1:0] pcieRdata
);

  typedef struct packed {
    sbrd_pkg::sbrd_state_type  state;
    sbrd_pkg::sbrd_region_type region;
    logic                      write;
    logic [AW-1:0]             addr;
    logic [DW-1:0]             wdata;
    logic [3:0]                be;
    logic                      swap;
    logic [7:0]                cnt;
    logic                      rvalid;
    logic [DW-1:0]             rdata;
    logic                      unsup;
    logic                      ack;
    logic                      run;
    logic                      bigEnd;
    logic                      strapTaken;
  } sbrd_regs_type;

  sbrd_regs_type r_q;
  sbrd_regs_type r_d;

  sbrd_pkg::sbrd_region_type reqRegion;
  logic [DW-1:0]             inWdata;
  logic [DW-1:0]             remoteRdata;
  logic                      remoteDone;
  logic                      fullWord;
  logic                      isReg;
  logic                      accept;
  logic                      posted;

  function automatic logic [DW-1:0] swapLanes(input logic [DW-1:0] v);
    swapLanes = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  // flash is also seen at the bottom of the map while boot mode is active
  always_comb begin
    reqRegion = sbrd_pkg::RegionNone;
    if (busAddr >= `SBRD_LOCAL_BASE && busAddr <= `SBRD_LOCAL_LAST) begin
      reqRegion = sbrd_pkg::RegionLocal;
    end else if (busAddr >= `SBRD_SWITCH_BASE && busAddr <= `SBRD_SWITCH_LAST) begin
      reqRegion = sbrd_pkg::RegionSwitch;
    end else if (busAddr >= `SBRD_FLASH_BASE && busAddr <= `SBRD_FLASH_LAST) begin
      reqRegion = sbrd_pkg::RegionFlash;
    end else if (bootMode && busAddr <= `SBRD_FLASH_LOWLAST) begin
      reqRegion = sbrd_pkg::RegionFlash;
    end else if (busAddr >= `SBRD_DDR_BASE && busAddr <= `SBRD_DDR_LAST) begin
      reqRegion = sbrd_pkg::RegionDdr;
    end else if (busAddr >= `SBRD_PCIE_BASE) begin
      reqRegion = sbrd_pkg::RegionPcie;
    end
  end

  // the swap applies only to processor traffic, never to inbound pcie
  assign inWdata  = (busFromCpu && r_q.bigEnd) ? swapLanes(busWdata) : busWdata;
  assign fullWord = (busBe == `SBRD_FULL_WORD);
  assign isReg    = (busAddr >= `SBRD_REGS_BASE && busAddr <= `SBRD_REGS_LAST);

  // a write may enter only an idle buffer; reads wait for the buffer to drain
  // the master still holds its request while an answer stands, so it is not taken twice
  assign accept   = busReq && (r_q.state == sbrd_pkg::BufIdle) && !r_q.ack;
  assign posted   = accept && busWrite && isReg;
  assign busStall = busReq && !(posted || r_q.ack);

  always_comb begin
    remoteDone  = 1'b0;
    remoteRdata = '0;
    unique case (r_q.region)
      sbrd_pkg::RegionLocal: begin
        remoteDone  = (r_q.cnt == 8'(`SBRD_LOCAL_CYC));
        remoteRdata = localRdata;
      end
      sbrd_pkg::RegionSwitch: begin
        // fast targets answer sooner; a busy second master shows up as late done
        remoteDone  = switchDone && (r_q.cnt >= (fastTarget ? 8'(FAST_CYCLES) : 8'h01));
        remoteRdata = switchRdata;
      end
      sbrd_pkg::RegionFlash: begin
        remoteDone  = flashDone;
        remoteRdata = flashRdata;
      end
      sbrd_pkg::RegionDdr: begin
        remoteDone  = ddrDone;
        remoteRdata = ddrRdata;
      end
      sbrd_pkg::RegionPcie: begin
        remoteDone  = pcieDone;
        remoteRdata = pcieRdata;
      end
      default: begin
        remoteDone  = 1'b1;
        remoteRdata = '0;
      end
    endcase
  end

  always_comb begin
    r_d        = r_q;
    r_d.rvalid = 1'b0;
    r_d.unsup  = 1'b0;
    r_d.ack    = 1'b0;
    // endianness caught once after reset from strap; followed from config every cycle when booting manually
    if (!r_q.strapTaken) begin
      r_d.strapTaken = 1'b1;
      r_d.bigEnd     = autoBootStrap ? bigEndianStrap : bigEndianCfg;
      r_d.run        = autoBootStrap;
    end else if (!autoBootStrap) begin
      r_d.bigEnd = bigEndianCfg;
      if (cpuStartCfg) begin
        r_d.run = 1'b1;
      end
    end
    unique case (r_q.state)
      sbrd_pkg::BufIdle: begin
        if (accept) begin
          if (isReg && !fullWord) begin
            r_d.unsup  = 1'b1;
            r_d.ack    = !busWrite;
            r_d.rvalid = !busWrite;
            r_d.rdata  = '0;
          end else if (busWrite && reqRegion == sbrd_pkg::RegionFlash) begin
            r_d.unsup = 1'b1;
            r_d.ack   = 1'b1;
          end else if (reqRegion == sbrd_pkg::RegionNone) begin
            r_d.unsup  = 1'b1;
            r_d.ack    = !(busWrite && isReg);
            r_d.rvalid = !busWrite;
            r_d.rdata  = '0;
          end else begin
            r_d.region = reqRegion;
            r_d.write  = busWrite;
            r_d.addr   = busAddr;
            r_d.wdata  = inWdata;
            r_d.be     = busBe;
            r_d.swap   = busFromCpu && r_q.bigEnd;
            r_d.cnt    = '0;
            r_d.state  = (busWrite && isReg) ? sbrd_pkg::BufBusy : sbrd_pkg::BufRead;
          end
        end
      end
      sbrd_pkg::BufBusy, sbrd_pkg::BufRead: begin
        r_d.cnt = (r_q.cnt == 8'hff) ? r_q.cnt : r_q.cnt + 8'h01;
        if (remoteDone) begin
          r_d.state  = sbrd_pkg::BufIdle;
          r_d.region = sbrd_pkg::RegionNone;
          if (r_q.state == sbrd_pkg::BufRead) begin
            // non-posted transfers release the master here; only reads carry data
            r_d.ack    = 1'b1;
            r_d.rvalid = !r_q.write;
            if (!r_q.write) begin
              r_d.rdata = r_q.swap ? swapLanes(remoteRdata) : remoteRdata;
            end
          end
        end
      end
      default: begin
        r_d.state = sbrd_pkg::BufIdle;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  logic active;
  assign active = (r_q.state != sbrd_pkg::BufIdle);

  // inbound pcie and access-block masters share this single issue port
  assign localReq     = active && r_q.region == sbrd_pkg::RegionLocal;
  assign localWrite   = r_q.write;
  assign localAddr    = r_q.addr;
  assign localWdata   = r_q.wdata;
  assign switchReq    = active && r_q.region == sbrd_pkg::RegionSwitch;
  assign switchWrite  = r_q.write;
  assign switchAddr   = r_q.addr;
  assign switchWdata  = r_q.wdata;
  assign flashReadReq = active && r_q.region == sbrd_pkg::RegionFlash;
  assign flashAddr    = r_q.addr;
  assign ddrReq       = active && r_q.region == sbrd_pkg::RegionDdr;
  assign ddrWrite     = r_q.write;
  assign ddrAddr      = r_q.addr;
  assign ddrWdata     = r_q.wdata;
  assign ddrBe        = r_q.be;
  assign pcieReq      = active && r_q.region == sbrd_pkg::RegionPcie;
  assign pcieWrite    = r_q.write;
  assign pcieAddr     = r_q.addr;
  assign pcieWdata    = r_q.wdata;
  assign pcieBe       = r_q.be;

  assign busRvalid      = r_q.rvalid;
  assign busRdata       = r_q.rdata;
  assign busUnsupported = r_q.unsup;
  assign cpuRun         = r_q.run;
  assign cpuBigEndian   = r_q.bigEnd;
  assign cpuResetVector = `SBRD_RESET_VECTOR;
  assign debugAttach    = !debug_attach_strap_n;
  assign cpuIrqIn       = devIrq;

  chk_post_release: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && busWrite && isReg && fullWord) |-> !busStall)
    else $error("posted register write was stalled");

  chk_write_stall: assert property (@(posedge ref_clk) disable iff (rst)
    (r_q.state == sbrd_pkg::BufBusy && busReq && busWrite) |-> busStall)
    else $error("write accepted while buffer busy");

  sequence readIssued;
    accept && !busWrite && fullWord &&
      (reqRegion == sbrd_pkg::RegionLocal || reqRegion == sbrd_pkg::RegionSwitch);
  endsequence
  chk_read_hold: assert property (@(posedge ref_clk) disable iff (rst)
    readIssued |=> (r_q.state == sbrd_pkg::BufRead) && !busRvalid)
    else $error("register read did not hold");

  chk_read_order: assert property (@(posedge ref_clk) disable iff (rst)
    (r_q.state == sbrd_pkg::BufBusy && busReq && !busWrite) |=> !busRvalid)
    else $error("read overtook pending write");

  chk_local_time: assert property (@(posedge ref_clk) disable iff (rst)
    (localReq && r_q.cnt == 8'h00) |-> ##[1:3] !localReq)
    else $error("local access too slow");

  chk_flash_ro: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && busWrite && reqRegion == sbrd_pkg::RegionFlash) |=>
      busUnsupported && !flashReadReq)
    else $error("flash write not refused");

  chk_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
    (r_q.state == sbrd_pkg::BufRead && remoteDone && !r_q.write) |=> busRvalid)
    else $error("read completion gave no data");

  chk_write_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (r_q.state == sbrd_pkg::BufRead && remoteDone && r_q.write) |=> !busRvalid)
    else $error("write completion gave read data");

  chk_partial_read: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && isReg && !fullWord && !busWrite) |=> busUnsupported && busRvalid)
    else $error("partial register read not refused");

  chk_partial_drop: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && isReg && !fullWord) |=> !localReq && !switchReq)
    else $error("partial register access issued");

  chk_debug_attach: assert property (@(posedge ref_clk) disable iff (rst)
    debugAttach == !debug_attach_strap_n)
    else $error("debug attach mismatch");

  chk_irq_map: assert property (@(posedge ref_clk) disable iff (rst)
    cpuIrqIn == devIrq)
    else $error("interrupt mapping wrong");

endmodule

// File: sbrd_target_model.sv
// responder standing in for the switch, flash, ddr and pcie targets
`timescale 1ns/1ps
module sbrd_target_model #(
  parameter int          DLY  = 4,
  parameter logic [15:0] SALT = 16'h5a00
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        fast,
  input  wire logic [31:0] addr,
  output logic             done,
  output logic [31:0]      rdata
);
  int          cnt;
  logic [31:0] word;
  assign word = {SALT, addr[15:0]};
  // data is only good with done; the inverse otherwise so a stale capture shows up
  assign rdata = done ? word : ~word;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt  <= 0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (req && !done) begin
        if (cnt >= (fast ? 1 : DLY) - 1) begin
          done <= 1'b1;
          cnt  <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule

// File: shared_bus_region_decoder_tb.sv
// self-checking bench for the shared bus region decoder
`timescale 1ns/1ps
module shared_bus_region_decoder_tb;
  logic        ref_clk, rst, busReq, busWrite, busFromCpu, bootMode, autoBootStrap;
  logic        bigEndianStrap, bigEndianCfg, cpuStartCfg, debug_attach_strap_n, fastTarget;
  logic        busStall, busRvalid, busUnsupported, cpuRun, cpuBigEndian, debugAttach;
  logic        localReq, localWrite, switchReq, switchWrite, flashReadReq, ddrReq, ddrWrite;
  logic        pcieReq, pcieWrite, switchDone, flashDone, ddrDone, pcieDone, gotUns, wr;
  logic [1:0]  devIrq, cpuIrqIn;
  logic [3:0]  busBe, ddrBe, pcieBe, gotBe, be;
  logic [4:0]  hits, tgt, e;
  logic [31:0] busAddr, busWdata, busRdata, cpuResetVector, localAddr, localWdata, localRdata;
  logic [31:0] switchAddr, switchWdata, switchRdata, flashAddr, flashRdata, a, d, r;
  logic [31:0] ddrAddr, ddrWdata, ddrRdata, pcieAddr, pcieWdata, pcieRdata;
  logic [31:0] gotAddr, gotData, gotRd, locVal, seed = 32'd25;
  logic [7:0]  bases [8] = '{8'h70, 8'h71, 8'h40, 8'h80, 8'hc0, 8'h50, 8'h00, 8'hb0};
  int          error_cnt = 0, samples_checked = 0, cycles = 0, waitCyc, stallCyc, base;
  int          txn = 0, txnSeen = 0;

  sbrd_decoder dut (.*);
  sbrd_target_model #(.DLY(10), .SALT(16'h5a02)) swm (.ref_clk(ref_clk), .rst(rst),
    .req(switchReq), .fast(fastTarget), .addr(switchAddr), .done(switchDone), .rdata(switchRdata));
  sbrd_target_model #(.SALT(16'h5a04)) flm (.ref_clk(ref_clk), .rst(rst),
    .req(flashReadReq), .fast(fastTarget), .addr(flashAddr), .done(flashDone),
    .rdata(flashRdata));
  sbrd_target_model #(.SALT(16'h5a08)) ddm (.ref_clk(ref_clk), .rst(rst),
    .req(ddrReq), .fast(fastTarget), .addr(ddrAddr), .done(ddrDone), .rdata(ddrRdata));
  sbrd_target_model #(.SALT(16'h5a10)) pcm (.ref_clk(ref_clk), .rst(rst),
    .req(pcieReq), .fast(fastTarget), .addr(pcieAddr), .done(pcieDone), .rdata(pcieRdata));

  assign tgt = {pcieReq, ddrReq, flashReadReq, switchReq, localReq};
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    // a new transaction number clears the record; only this process drives hits
    if (txn != txnSeen) begin
      txnSeen <= txn;
      hits    <= '0;
    end else if (|tgt) begin
      hits <= hits | tgt;
    end
    if (|tgt) begin
      gotAddr <= localReq ? localAddr : switchReq ? switchAddr : ddrReq ? ddrAddr : pcieAddr;
      gotData <= localReq ? localWdata : switchReq ? switchWdata : ddrReq ? ddrWdata : pcieWdata;
      gotBe   <= ddrReq ? ddrBe : pcieBe;
    end
  end
  always @(posedge ref_clk) begin
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] swap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  // flash mirror at the bottom only while boot mode is on; partial words refused in registers
  function automatic logic [4:0] exp_tgt(input logic w, input logic [31:0] x, input logic [3:0] b);
    if (x[31:24] == 8'h70) return (b == 4'hf) ? 5'h01 : 5'h00;
    if (x[31:24] == 8'h71) return (b == 4'hf) ? 5'h02 : 5'h00;
    if (x[31:28] == 4'h4 || x[31:28] == 4'h0) return w ? 5'h00 : 5'h04;
    if (x[31:30] == 2'b10) return 5'h08;
    if (x[31:30] == 2'b11) return 5'h10;
    return 5'h00;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [4:0] t, input logic [31:0] x);
    return (t == 5'h01) ? locVal : {16'h5a00 | {11'h0, t}, x[15:0]};
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ends at the falling edge where the answer is seen; the caller releases or chains
  task automatic access(input logic w, input logic [31:0] x, y, input logic [3:0] b,
                        input logic cpu);
    txn++;
    gotUns = 1'b0;
    gotRd = 'x;
    waitCyc = 0;
    stallCyc = 0;
    locVal = xs();
    @(posedge ref_clk);
    busReq <= 1'b1;
    busWrite <= w;
    busAddr <= x;
    busWdata <= y;
    busBe <= b;
    busFromCpu <= cpu;
    localRdata <= locVal;
    do begin
      @(negedge ref_clk);
      waitCyc++;
      stallCyc += int'(busStall);
      gotUns |= busUnsupported;
      if (busRvalid) gotRd = busRdata;
    end while (busStall && waitCyc < 300);
    check("released", 0, busStall);
  endtask
  task automatic fin();
    @(posedge ref_clk);
    busReq <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge ref_clk);
      gotUns |= busUnsupported;
      if (i > 1 && !(|tgt)) break;
    end
  endtask
  task automatic do_reset(input logic auto, input logic strap, input logic start);
    @(posedge ref_clk);
    rst <= 1'b1;
    autoBootStrap <= auto;
    bigEndianStrap <= strap;
    cpuStartCfg <= start;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {rst, busReq, busWrite, busFromCpu, bootMode, fastTarget, bigEndianCfg} = 7'h40;
    {autoBootStrap, bigEndianStrap, cpuStartCfg, debug_attach_strap_n} = 4'hf;
    {busAddr, busWdata, localRdata} = '0;
    busBe = 4'hf;
    devIrq = 2'h0;
    do_reset(1'b1, 1'b1, 1'b0);
    check("run", 1, cpuRun);
    check("bigend", 1, cpuBigEndian);
    check("vector", 0, cpuResetVector);
    d = xs();
    access(1'b1, 32'h80000100, d, 4'hf, 1'b1);
    fin();
    check("cpu wdata", swap(d), gotData);
    access(1'b0, 32'h80000204, 0, 4'hf, 1'b1);
    fin();
    check("cpu rdata", swap(32'h5a080204), gotRd);
    do_reset(1'b0, 1'b1, 1'b1);
    check("run", 1, cpuRun);
    check("bigend", 0, cpuBigEndian);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      devIrq <= 2'(i);
      debug_attach_strap_n <= i[0];
      @(negedge ref_clk);
      check("irq", i, cpuIrqIn);
      check("debug", !i[0], debugAttach);
    end
    access(1'b0, 32'h70000014, 0, 4'hf, 1'b0);
    fin();
    base = stallCyc;
    access(1'b1, 32'h70000010, xs(), 4'hf, 1'b0);
    check("posted", 0, stallCyc);
    access(1'b1, 32'h70000014, xs(), 4'hf, 1'b0);
    check("second write stall", 1, stallCyc > 0);
    access(1'b0, 32'h70000014, 0, 4'hf, 1'b0);
    check("read waits write", 1, stallCyc > base);
    check("read data", locVal, gotRd);
    fin();
    for (int f = 0; f < 2; f++) begin
      @(posedge ref_clk);
      fastTarget <= f[0];
      access(1'b0, 32'h71000040, 0, 4'hf, 1'b0);
      fin();
      if (f == 0) check("slow", 1, waitCyc >= 10);
      else check("fast", 1, waitCyc <= 4);
      check("switch rdata", 32'h5a020040, gotRd);
    end
    for (int n = 0; n < 60; n++) begin
      r = xs();
      a = {bases[r[2:0]], r[31:10], 2'b00};
      wr = r[3];
      be = (r[7:4] == 4'h0) ? r[11:8] : 4'hf;
      d = xs();
      @(posedge ref_clk);
      bootMode <= (r[2:0] == 3'd6);
      fastTarget <= r[12];
      e = exp_tgt(wr, a, be);
      access(wr, a, d, be, 1'b0);
      fin();
      check("target", 32'(e), 32'(hits));
      check("refused", 32'(e == 5'h0), 32'(gotUns));
      if (e != 5'h0 && e != 5'h04) check("addr", a, gotAddr);
      if (wr && e != 5'h0) check("wdata", d, gotData);
      if (wr && e[4:3] != 2'b0) check("be", 32'(be), 32'(gotBe));
      if (!wr && e != 5'h0) check("rdata", exp_rd(e, a), gotRd);
    end
    wrap_up();
  end
endmodule
